// ===== bench/tbs_drive_model.sv
// Drive side model: contacts, terminal-3 voltage, start and load torque
`timescale 1ns/1ps
module tbs_drive_model (
   input  wire               clk_i,
   input  wire               a_i,
   input  wire               b_i,
   input  wire               start_i,
   input  wire               pre_i,
   input  wire               rev_i,
   input  wire        [15:0] volt_i,
   input  wire signed [15:0] load_i,
   output reg                a_o,
   output reg                b_o,
   output reg                start_o,
   output reg                pre_o,
   output reg                rev_o,
   output reg         [15:0] volt_o,
   output reg  signed [15:0] load_o
);
   // Contacts and terminals settle one cycle after the operator acts
   always @(posedge clk_i) begin
      a_o     <= a_i;
      b_o     <= b_i;
      start_o <= start_i;
      pre_o   <= pre_i;
      rev_o   <= rev_i;
      volt_o  <= volt_i;
      load_o  <= load_i;
   end
endmodule // tbs_drive_model

// ===== bench/tbs_props.sv
// Checker of bus handshakes and bias timing at the top ports
`timescale 1ns/1ps
module tbs_props (
   input wire               clk_i,
   input wire               srst_i,
   input wire               s_axi_awvalid_i,
   input wire               s_axi_awready_o,
   input wire               s_axi_wvalid_i,
   input wire               s_axi_wready_o,
   input wire               s_axi_bvalid_o,
   input wire               s_axi_bready_i,
   input wire               s_axi_arready_o,
   input wire               s_axi_rvalid_o,
   input wire               s_axi_rready_i,
   input wire        [31:0] s_axi_rdata_o,
   input wire               start_i,
   input wire               pre_excite_i,
   input wire signed [15:0] torque_bias_o,
   input wire               bias_hold_o,
   input wire               bias_active_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);
   // Answers stand until the master takes them
   rvalid_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o) else $error("read answer dropped early");
   bvalid_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o) else $error("write answer dropped early");
   rdata_upper_a: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:16] == 16'h0000) else $error("read data upper half not zero");
   read_busy_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o) else $error("address taken while answer pending");
   write_resp_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o |-> ##[1:2] s_axi_bvalid_o) else $error("write answer missing");
   // Bias follows the start command when no pre-excitation runs
   stop_idle_a: assert property (!start_i |=> !bias_active_o) else $error("bias active without start");
   pre_block_a: assert property (pre_excite_i |=> !bias_active_o) else $error("bias active during pre-excitation");
   start_cause_a: assert property ($rose(bias_active_o) |-> $past(start_i) && !$past(pre_excite_i)) else $error("bias began without run");
   hold_cause_a: assert property ($rose(bias_hold_o) |-> $past(start_i)) else $error("hold began without start");
   bias_range_a: assert property (torque_bias_o >= -16'sd400 && torque_bias_o <= 16'sd400) else $error("bias beyond 400 percent");
   // Main scenarios
   cover property (s_axi_bvalid_o && s_axi_bready_i);
   cover property (s_axi_rvalid_o && s_axi_rready_i);
   cover property ($rose(bias_hold_o));
   cover property (bias_active_o && torque_bias_o < 0);
endmodule // tbs_props

// ===== bench/tbs_top_tb.sv
// Self-checking bench of the torque bias selector
`timescale 1ns/1ps
`include "tbs_consts.vh"
module tbs_top_tb;
   reg clk_i = 1'b0, srst_i = 1'b1;
   reg [7:0] awaddr = 8'h00, araddr = 8'h00;
   reg [31:0] wdata = 32'h00000000;
   reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1;
   reg arvalid = 1'b0, rready = 1'b1;
   reg m_a = 1'b0, m_b = 1'b0, m_start = 1'b0, m_pre = 1'b0, m_rev = 1'b0;
   reg [15:0] m_v = 16'h0000, m_load = 16'h0000;
   wire d_a, d_b, d_start, d_pre, d_rev;
   wire [15:0] d_v, d_load;
   wire awready, wready, bvalid, arready, rvalid, hold, active;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire signed [15:0] bias;
   reg [1:0] resp;
   reg [31:0] rd_word;
   integer errors = 0, comparisons = 0, cycles = 0, k;
   reg [35:0] rows [0:8];
   tbs_drive_model tbs_drive_model_i (.clk_i(clk_i), .a_i(m_a), .b_i(m_b),
      .start_i(m_start), .pre_i(m_pre), .rev_i(m_rev), .volt_i(m_v),
      .load_i(m_load), .a_o(d_a), .b_o(d_b), .start_o(d_start),
      .pre_o(d_pre), .rev_o(d_rev), .volt_o(d_v), .load_o(d_load));
   tbs_top #(.TICK_CYCLES(4)) tbs_top_i (.clk_i(clk_i), .srst_i(srst_i),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
      .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
      .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready), .bias_select_input_a_i(d_a),
      .bias_select_input_b_i(d_b), .analog_t3_i(d_v),
      .torque_fb_i(d_load), .start_i(d_start), .pre_excite_i(d_pre),
      .dir_rev_i(d_rev), .torque_bias_o(bias), .bias_hold_o(hold),
      .bias_active_o(active));
   // Clock of 100 MHz
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   // Cuts a hung run short
   always @(posedge clk_i) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         errors = errors + 1;
         wrap_up;
      end
   end
   task wrap_up;
      begin
         $display("comparisons %0d errors %0d", comparisons, errors);
         if (errors == 0 && comparisons > 0) $display("*** PASS ***");
         else $display("*** FAIL ***");
         $finish;
      end
   endtask
   task chk32(input [31:0] g, input [31:0] e);
      begin
         comparisons = comparisons + 1;
         if (g !== e) begin
            errors = errors + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
         end
      end
   endtask
   task chk16(input [15:0] g, input [15:0] e);
      chk32({16'h0000, g}, {16'h0000, e});
   endtask
   task chk1(input g, input e);
      chk32({31'h0, g}, {31'h0, e});
   endtask
   // Register write; bready stays high, answer taken when seen
   task wr(input [3:0] i, input [15:0] d);
      begin
         awaddr <= {2'b00, i, 2'b00};
         wdata <= {16'h0000, d};
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         @(posedge clk_i);
         while (!bvalid) begin
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            @(posedge clk_i);
         end
         resp = bresp;
      end
   endtask
   // Register read; rready stays high
   task rd(input [3:0] i);
      begin
         araddr <= {2'b00, i, 2'b00};
         arvalid <= 1'b1;
         @(posedge clk_i);
         while (!rvalid) begin
            if (arready) arvalid <= 1'b0;
            @(posedge clk_i);
         end
         resp = rresp;
         rd_word = rdata;
      end
   endtask
   task go(input integer n);
      begin
         m_start <= 1'b1;
         repeat (n) @(posedge clk_i);
      end
   endtask
   task halt(input [8*8-1:0] name);
      begin
         m_start <= 1'b0;
         repeat (4) @(posedge clk_i);
         $display("test %0s done", name);
      end
   endtask
   initial begin
      // Rows: contact a, contact b, slot, slot value, expected bias
      rows[0] = {1'b1, 1'b0, 2'd1, 16'h0401, 16'h0019};
      rows[1] = {1'b0, 1'b1, 2'd2, 16'h03CF, 16'hFFE7};
      rows[2] = {1'b1, 1'b1, 2'd3, 16'h039D, 16'hFFB5};
      rows[3] = {1'b0, 1'b0, 2'd1, 16'h0401, 16'h0000};
      rows[4] = {1'b1, 1'b0, 2'd1, 16'h0258, 16'hFE70};
      rows[5] = {1'b1, 1'b0, 2'd1, 16'h0578, 16'h0190};
      rows[6] = {1'b1, 1'b0, 2'd1, 16'h03E7, 16'hFFFF};
      rows[7] = {1'b1, 1'b0, 2'd1, 16'h270F, 16'h0000};
      rows[8] = {1'b1, 1'b0, 2'd1, 16'h0579, 16'h0000};
      repeat (6) @(posedge clk_i);
      srst_i <= 1'b0;
      @(posedge clk_i);
      // Reset values and refused accesses
      for (k = 0; k < 11; k = k + 1) begin
         rd(k[3:0]);
         chk32(rd_word, k == 9 ? 32'h00000000 : k == 10 ? 32'h00000064 : 32'h0000270F);
      end
      rd(4'hC);
      chk32({14'h0, resp, rd_word[15:0]}, {14'h0, `TBS_RESP_SLVERR, 16'h0000});
      wr(`TBS_IDX_STATUS, 16'h000F);
      chk16({14'h0, resp}, {14'h0, `TBS_RESP_SLVERR});
      halt("regs");
      // Contact selection table
      wr(`TBS_IDX_SEL, `TBS_SEL_SLOTS);
      for (k = 0; k < 9; k = k + 1) begin
         wr({2'b00, rows[k][33:32]}, rows[k][31:16]);
         m_a <= rows[k][35];
         m_b <= rows[k][34];
         go(8);
         chk16(bias, rows[k][15:0]);
         halt("slots");
      end
      // Hold time of three ticks, then pre-excitation
      wr(1, 16'h0401);
      wr(`TBS_IDX_HOLD, 16'h0003);
      go(6);
      chk1(hold, 1'b1);
      repeat (20) @(posedge clk_i);
      chk1(hold, 1'b0);
      chk1(active, 1'b1);
      m_pre <= 1'b1;
      repeat (6) @(posedge clk_i);
      chk1(active, 1'b0);
      m_pre <= 1'b0;
      repeat (6) @(posedge clk_i);
      chk16(bias, 16'h0019);
      wr(`TBS_IDX_HOLD, `TBS_UNSET);
      halt("hold");
      // Lag filter slows the rise
      wr(`TBS_IDX_FILTER, 16'h0004);
      go(6);
      chk1(bias < 16'sd25, 1'b1);
      wr(`TBS_IDX_FILTER, `TBS_UNSET);
      halt("filter");
      // Disabled selection
      wr(`TBS_IDX_SEL, `TBS_UNSET);
      go(8);
      chk32({15'h0, active, bias}, 32'h0);
      halt("off");
      // Analog selections, balance and lowering points
      m_v <= 16'h01F4;
      wr(`TBS_IDX_SEL, `TBS_SEL_ANA_FWD);
      go(8);
      chk16(bias, 16'h0032);
      halt("fwd");
      wr(`TBS_IDX_BALANCE, 16'h00C8);
      go(8);
      chk16(bias, 16'h001E);
      wr(`TBS_IDX_BALANCE, `TBS_UNSET);
      wr(`TBS_IDX_LOW_BIAS, 16'h0014);
      wr(`TBS_IDX_LOW_GAIN, 16'h0078);
      m_rev <= 1'b1;
      halt("balance");
      go(8);
      chk16(bias, 16'h0046);
      wr(`TBS_IDX_LOW_BIAS, `TBS_UNSET);
      wr(`TBS_IDX_LOW_GAIN, `TBS_UNSET);
      halt("lower");
      go(8);
      chk16(bias, 16'h0032);
      halt("reuse");
      m_v <= 16'h012C;
      wr(`TBS_IDX_SEL, `TBS_SEL_ANA_REV);
      go(8);
      chk16(bias, 16'h001E);
      halt("rev");
      // Automatic setting from the load, then normal run
      m_rev <= 1'b0;
      m_v <= 16'h01A4;
      m_load <= 16'hFF6A;
      wr(`TBS_IDX_SEL, `TBS_SEL_AUTO);
      go(16);
      chk16(bias, 16'h0000);
      rd(`TBS_IDX_ANA_BIAS);
      chk32(rd_word, 32'h00000096);
      rd(`TBS_IDX_ANA_GAIN);
      chk32(rd_word, 32'h00000096);
      rd(`TBS_IDX_BALANCE);
      chk32(rd_word, 32'h000001A4);
      rd(`TBS_IDX_STATUS);
      chk1(rd_word[`TBS_ST_AUTO_DONE], 1'b1);
      halt("auto");
      wr(`TBS_IDX_SEL, `TBS_SEL_ANA_FWD);
      m_v <= 16'h02BC;
      go(8);
      chk16(bias, 16'h0096);
      halt("resume");
      wrap_up;
   end
endmodule // tbs_top_tb
bind tbs_top tbs_props tbs_props_i (.*);

// ===== verilog/tbs_consts.vh
// Constants and register map of the torque bias selector
// Overview of operation
// - Selection 0 takes the bias from three preset slots chosen by contacts.
// - Selection 1 maps terminal-3 input to bias, raising on forward rotation.
// - Selection 2 maps terminal-3 input to bias, raising on reverse rotation.
// - Selection 3 fills analog bias and gain from the load, balance voltage from terminal-3 input.
// - Contacts off none, A only slot1, B only slot2, both slot3.
// - Slot value 1000 is zero bias; rated torque is 100.
// - Slot values 600 to 999 give -400 to -1 percent.
// - Slot values 1000 to 1400 give 0 to 400 percent.
// - A slot holding 9999 gives no bias.
// - Bias passes a first-order lag of 0 to 5 s; 9999 is zero.
// - After start, torque is bias alone for the hold time; 9999 is zero.
// - Balance voltage 0 to 10 V marks balanced load; 9999 is 0 V.
// - Lowering uses its own bias point; 9999 reuses the forward one.
// - Lowering uses its own gain point; 9999 reuses the forward one.
// - Selection 9999 disables the torque bias entirely; the hold timer still sets bias_hold_o for the hold time after start.
// - Without pre-excitation the bias starts with the start command.
`ifndef TBS_CONSTS_VH
`define TBS_CONSTS_VH
// Register indices; byte address is four times the index
`define TBS_IDX_SEL        4'h0
`define TBS_IDX_SLOT1      4'h1
`define TBS_IDX_FILTER     4'h4
`define TBS_IDX_HOLD       4'h5
`define TBS_IDX_BALANCE    4'h6
`define TBS_IDX_LOW_BIAS   4'h7
`define TBS_IDX_LOW_GAIN   4'h8
`define TBS_IDX_ANA_BIAS   4'h9
`define TBS_IDX_ANA_GAIN   4'hA
`define TBS_IDX_STATUS     4'hB
`define TBS_NUM_CFG        11
// Reset values and special codes
`define TBS_UNSET          16'h270F
`define TBS_ANA_BIAS_RST   16'h0000
`define TBS_ANA_GAIN_RST   16'h0064
// Selection codes
`define TBS_SEL_SLOTS      16'h0000
`define TBS_SEL_ANA_FWD    16'h0001
`define TBS_SEL_ANA_REV    16'h0002
`define TBS_SEL_AUTO       16'h0003
// Slot encoding, percent of rated torque
`define TBS_SLOT_MIN       16'h0258
`define TBS_SLOT_MAX       16'h0578
`define TBS_SLOT_CENTRE    16'h03E8
`define TBS_PCT_MAX        16'h0190
// Terminal-3 full scale, 10 V in 10 mV steps
`define TBS_VOLT_FULL      16'h03E8
// Time base of filter and hold registers
`define TBS_TIME_LSB_NS    10000000
`define TBS_CLK_PERIOD_NS  10
`define TBS_FRAC_BITS      8
// Status bit positions
`define TBS_ST_ACTIVE      0
`define TBS_ST_HOLD        1
`define TBS_ST_AUTO_DONE   2
`define TBS_ST_LOWERING    3
// Bus responses
`define TBS_RESP_OKAY      2'b00
`define TBS_RESP_SLVERR    2'b10
`endif

// ===== verilog/tbs_hold_timer.v
// Timer that holds torque at the bias value after start
`timescale 1ns/1ps
`include "tbs_consts.vh"
module tbs_hold_timer (
   input  wire        clk_i,
   input  wire        srst_i,
   input  wire        start_i,
   input  wire        run_i,
   input  wire        tick_i,
   input  wire [15:0] hold_ticks_i,
   output wire        active_o
);
   reg        active_reg;
   reg [15:0] count_reg;

   // Load on start, count ticks down, stop on zero or when run drops
   always @(posedge clk_i) begin
      if (srst_i) begin
         active_reg <= 1'b0;
         count_reg  <= 16'h0000;
      end else if (start_i) begin
         active_reg <= (hold_ticks_i != 16'h0000);
         count_reg  <= hold_ticks_i;
      end else if (!run_i) begin
         active_reg <= 1'b0;
         count_reg  <= 16'h0000;
      end else if (tick_i && active_reg) begin
         count_reg  <= count_reg - 16'h0001;
         active_reg <= (count_reg != 16'h0001);
      end
   end

   assign active_o = active_reg;
endmodule // tbs_hold_timer

// ===== verilog/tbs_lag_filter.v
// First-order lag applied to the torque bias command
`timescale 1ns/1ps
`include "tbs_consts.vh"
module tbs_lag_filter (
   input  wire               clk_i,
   input  wire               srst_i,
   input  wire               tick_i,
   input  wire signed [15:0] x_i,
   input  wire        [15:0] tc_i,
   output wire signed [15:0] y_o
);
   reg  signed [23:0] acc_reg;
   reg  signed [23:0] acc_next;
   wire signed [24:0] target;
   wire signed [24:0] diff;
   wire signed [24:0] step;
   wire signed [24:0] div;

   // Target in fixed point, step is error over time constant plus one
   assign target = {{1{x_i[15]}}, x_i, {`TBS_FRAC_BITS{1'b0}}};
   assign diff   = target - {acc_reg[23], acc_reg};
   assign div    = $signed({9'h000, tc_i}) + 25'sh0000001;
   assign step   = diff / div;
   assign y_o    = acc_reg[23:`TBS_FRAC_BITS];

   // Zero constant follows at once, otherwise steps once per tick
   always @* begin
      acc_next = acc_reg;
      if (tc_i == 16'h0000) begin
         acc_next = target[23:0];
      end else if (tick_i) begin
         acc_next = acc_reg + step[23:0];
      end
   end

   always @(posedge clk_i) begin
      if (srst_i) begin
         acc_reg <= 24'sh000000;
      end else begin
         acc_reg <= acc_next;
      end
   end
endmodule // tbs_lag_filter

// ===== verilog/tbs_top.v
// Torque bias selector with AXI4-Lite register access
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "tbs_consts.vh"
module tbs_top #(
   parameter TICK_CYCLES = `TBS_TIME_LSB_NS / `TBS_CLK_PERIOD_NS
) (
   input  wire        clk_i,
   input  wire        srst_i,
   // AXI4-Lite slave
   input  wire [7:0]  s_axi_awaddr_i,
   input  wire        s_axi_awvalid_i,
   output wire        s_axi_awready_o,
   input  wire [31:0] s_axi_wdata_i,
   input  wire [3:0]  s_axi_wstrb_i,
   input  wire        s_axi_wvalid_i,
   output wire        s_axi_wready_o,
   output wire [1:0]  s_axi_bresp_o,
   output wire        s_axi_bvalid_o,
   input  wire        s_axi_bready_i,
   input  wire [7:0]  s_axi_araddr_i,
   input  wire        s_axi_arvalid_i,
   output wire        s_axi_arready_o,
   output wire [31:0] s_axi_rdata_o,
   output wire [1:0]  s_axi_rresp_o,
   output wire        s_axi_rvalid_o,
   input  wire        s_axi_rready_i,
   // Contact, analog and drive state inputs
   input  wire        bias_select_input_a_i,
   input  wire        bias_select_input_b_i,
   input  wire [15:0] analog_t3_i,
   input  wire signed [15:0] torque_fb_i,
   input  wire        start_i,
   input  wire        pre_excite_i,
   input  wire        dir_rev_i,
   // Torque command path
   output wire signed [15:0] torque_bias_o,
   output wire        bias_hold_o,
   output wire        bias_active_o
);
   // Auto setting states
   localparam [1:0] AUTO_IDLE = 2'b00;
   localparam [1:0] AUTO_MEAS = 2'b01;
   localparam [1:0] AUTO_DONE = 2'b10;

   reg  [15:0] cfg_reg [0:`TBS_NUM_CFG-1];
   reg         awready_reg;
   reg         wready_reg;
   reg         aw_full_reg;
   reg         w_full_reg;
   reg  [7:0]  awaddr_reg;
   reg  [31:0] wdata_reg;
   reg  [3:0]  wstrb_reg;
   reg         bvalid_reg;
   reg  [1:0]  bresp_reg;
   reg         arready_reg;
   reg         rvalid_reg;
   reg  [31:0] rdata_reg;
   reg  [1:0]  rresp_reg;
   reg  [31:0] tick_cnt_reg;
   reg         tick_reg;
   reg         run_reg;
   reg  [1:0]  auto_reg;
   reg  [1:0]  auto_next;
   reg signed [15:0] torque_bias_reg;
   reg         hold_reg;
   reg         active_reg;
   reg signed [15:0] target;
   reg signed [15:0] slot_pct;
   reg  [15:0] slot_raw;
   reg  [15:0] fb_mag;
   reg  [15:0] auto_pct;
   integer     i;

   wire        wr_go;
   wire [3:0]  wr_idx;
   wire        wr_ok;
   wire [3:0]  rd_idx;
   wire        rd_ok;
   wire [15:0] sel;
   wire        run_now;
   wire        run_start;
   wire        lowering;
   wire [15:0] bal_v;
   wire [15:0] pt_bias;
   wire [15:0] pt_gain;
   wire signed [17:0] v_eff;
   wire signed [17:0] span;
   wire signed [35:0] prod;
   wire signed [35:0] quot;
   wire signed [35:0] ana_sum;
   wire signed [15:0] ana_pct;
   wire [15:0] filt_tc;
   wire [15:0] hold_ticks;
   wire signed [15:0] filt_y;
   wire        hold_act;
   wire [31:0] status;

   // Byte-lane merge into a 16-bit register, upper lanes have no storage
   function [15:0] merge16;
      input [15:0] old;
      input [31:0] data;
      input [3:0]  strb;
      begin
         merge16[7:0]  = strb[0] ? data[7:0]  : old[7:0];
         merge16[15:8] = strb[1] ? data[15:8] : old[15:8];
      end
   endfunction

   // Write address and data are taken in either order
   assign wr_go  = aw_full_reg && w_full_reg && !bvalid_reg;
   assign wr_idx = awaddr_reg[5:2];
   assign wr_ok  = (awaddr_reg[7:6] == 2'b00) &&
                   (wr_idx < `TBS_IDX_STATUS);

   always @(posedge clk_i) begin
      if (srst_i) begin
         awready_reg <= 1'b0;
         wready_reg  <= 1'b0;
         aw_full_reg <= 1'b0;
         w_full_reg  <= 1'b0;
         awaddr_reg  <= 8'h00;
         wdata_reg   <= 32'h00000000;
         wstrb_reg   <= 4'h0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= `TBS_RESP_OKAY;
      end else begin
         awready_reg <= !aw_full_reg && !(awready_reg && s_axi_awvalid_i);
         wready_reg  <= !w_full_reg && !(wready_reg && s_axi_wvalid_i);
         if (awready_reg && s_axi_awvalid_i) begin
            aw_full_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr_i;
         end
         if (wready_reg && s_axi_wvalid_i) begin
            w_full_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata_i;
            wstrb_reg  <= s_axi_wstrb_i;
         end
         if (wr_go) begin
            aw_full_reg <= 1'b0;
            w_full_reg  <= 1'b0;
            bvalid_reg  <= 1'b1;
            bresp_reg   <= wr_ok ? `TBS_RESP_OKAY : `TBS_RESP_SLVERR;
         end else if (bvalid_reg && s_axi_bready_i) begin
            bvalid_reg  <= 1'b0;
         end
      end
   end

   // Read channel, one read under way at a time
   assign rd_idx = s_axi_araddr_i[5:2];
   assign rd_ok  = (s_axi_araddr_i[7:6] == 2'b00) &&
                   (rd_idx <= `TBS_IDX_STATUS);
   assign status = {28'h0000000, lowering, auto_reg == AUTO_DONE,
                    hold_reg, active_reg};

   always @(posedge clk_i) begin
      if (srst_i) begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= 32'h00000000;
         rresp_reg   <= `TBS_RESP_OKAY;
      end else begin
         arready_reg <= !rvalid_reg && !(arready_reg && s_axi_arvalid_i);
         if (arready_reg && s_axi_arvalid_i) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= rd_ok ? `TBS_RESP_OKAY : `TBS_RESP_SLVERR;
            if (!rd_ok) begin
               rdata_reg <= 32'h00000000;
            end else if (rd_idx == `TBS_IDX_STATUS) begin
               rdata_reg <= status;
            end else begin
               rdata_reg <= {16'h0000, cfg_reg[rd_idx]};
            end
         end else if (rvalid_reg && s_axi_rready_i) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   // Configuration registers; the auto capture wins over a bus write
   always @(posedge clk_i) begin
      if (srst_i) begin
         for (i = 0; i < `TBS_NUM_CFG; i = i + 1) begin
            cfg_reg[i] <= `TBS_UNSET;
         end
         cfg_reg[`TBS_IDX_ANA_BIAS] <= `TBS_ANA_BIAS_RST;
         cfg_reg[`TBS_IDX_ANA_GAIN] <= `TBS_ANA_GAIN_RST;
      end else begin
         if (wr_go && wr_ok) begin
            cfg_reg[wr_idx] <= merge16(cfg_reg[wr_idx], wdata_reg,
                                       wstrb_reg);
         end
         if (auto_reg == AUTO_MEAS && auto_next == AUTO_DONE) begin
            cfg_reg[`TBS_IDX_BALANCE]  <= analog_t3_i;
            cfg_reg[`TBS_IDX_ANA_BIAS] <= auto_pct;
            cfg_reg[`TBS_IDX_ANA_GAIN] <= auto_pct;
         end
      end
   end

   // Time base tick every register LSB of time
   always @(posedge clk_i) begin
      if (srst_i) begin
         tick_cnt_reg <= 32'h00000000;
         tick_reg     <= 1'b0;
      end else if (tick_cnt_reg == TICK_CYCLES - 1) begin
         tick_cnt_reg <= 32'h00000000;
         tick_reg     <= 1'b1;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
         tick_reg     <= 1'b0;
      end
   end

   // Run begins with start unless pre-excitation is in progress
   assign sel       = cfg_reg[`TBS_IDX_SEL];
   assign run_now   = start_i && !pre_excite_i;
   assign run_start = run_now && !run_reg;

   always @(posedge clk_i) begin
      if (srst_i) begin
         run_reg <= 1'b0;
      end else begin
         run_reg <= run_now;
      end
   end

   // Preset slot chosen by the two contacts
   always @* begin
      case ({bias_select_input_b_i, bias_select_input_a_i})
         2'b01:   slot_raw = cfg_reg[`TBS_IDX_SLOT1];
         2'b10:   slot_raw = cfg_reg[`TBS_IDX_SLOT1 + 4'h1];
         2'b11:   slot_raw = cfg_reg[`TBS_IDX_SLOT1 + 4'h2];
         default: slot_raw = `TBS_UNSET;
      endcase
      // Offset code around the centre, unset or out of range is zero
      if (slot_raw >= `TBS_SLOT_MIN && slot_raw <= `TBS_SLOT_MAX) begin
         slot_pct = $signed(slot_raw - `TBS_SLOT_CENTRE);
      end else begin
         slot_pct = 16'sh0000;
      end
   end

   // Lowering is the direction opposite the raising one
   assign lowering = (sel == `TBS_SEL_ANA_REV) ? !dir_rev_i : dir_rev_i;
   assign bal_v    = (cfg_reg[`TBS_IDX_BALANCE] == `TBS_UNSET) ?
                     16'h0000 : cfg_reg[`TBS_IDX_BALANCE];
   assign pt_bias  = (lowering &&
                      cfg_reg[`TBS_IDX_LOW_BIAS] != `TBS_UNSET) ?
                     cfg_reg[`TBS_IDX_LOW_BIAS] :
                     cfg_reg[`TBS_IDX_ANA_BIAS];
   assign pt_gain  = (lowering &&
                      cfg_reg[`TBS_IDX_LOW_GAIN] != `TBS_UNSET) ?
                     cfg_reg[`TBS_IDX_LOW_GAIN] :
                     cfg_reg[`TBS_IDX_ANA_GAIN];

   // Linear map from balance-corrected voltage to bias
   assign v_eff   = $signed({2'b00, analog_t3_i}) -
                    $signed({2'b00, bal_v});
   assign span    = $signed({2'b00, pt_gain}) - $signed({2'b00, pt_bias});
   assign prod    = span * v_eff;
   assign quot    = prod / $signed({20'h00000, `TBS_VOLT_FULL});
   assign ana_sum = quot + $signed({20'h00000, pt_bias});
   assign ana_pct =
      (ana_sum > $signed({20'h00000, `TBS_PCT_MAX})) ?
         $signed(`TBS_PCT_MAX) :
      (ana_sum < -$signed({20'h00000, `TBS_PCT_MAX})) ?
         -$signed(`TBS_PCT_MAX) : ana_sum[15:0];

   // Source selection of the bias target
   always @* begin
      target = 16'sh0000;
      if (run_now) begin
         case (sel)
            `TBS_SEL_SLOTS:   target = slot_pct;
            `TBS_SEL_ANA_FWD: target = ana_pct;
            `TBS_SEL_ANA_REV: target = ana_pct;
            default:          target = 16'sh0000;
         endcase
      end
   end

   // Magnitude of measured load torque for auto setting
   always @* begin
      fb_mag   = torque_fb_i[15] ? 16'h0000 - torque_fb_i : torque_fb_i;
      auto_pct = (fb_mag > `TBS_PCT_MAX) ? `TBS_PCT_MAX : fb_mag;
   end

   // Auto setting measures once the hold period of a run has ended
   always @* begin
      auto_next = auto_reg;
      case (auto_reg)
         AUTO_IDLE: begin
            if (sel == `TBS_SEL_AUTO && run_start) begin
               auto_next = AUTO_MEAS;
            end
         end
         AUTO_MEAS: begin
            if (sel != `TBS_SEL_AUTO || !run_now) begin
               auto_next = AUTO_IDLE;
            end else if (tick_reg && !hold_act) begin
               auto_next = AUTO_DONE;
            end
         end
         AUTO_DONE: begin
            if (sel != `TBS_SEL_AUTO) begin
               auto_next = AUTO_IDLE;
            end
         end
         default: auto_next = AUTO_IDLE;
      endcase
   end

   always @(posedge clk_i) begin
      if (srst_i) begin
         auto_reg <= AUTO_IDLE;
      end else begin
         auto_reg <= auto_next;
      end
   end

   // Filter and hold times, unset counts as zero
   assign filt_tc    = (cfg_reg[`TBS_IDX_FILTER] == `TBS_UNSET) ?
                       16'h0000 : cfg_reg[`TBS_IDX_FILTER];
   assign hold_ticks = (cfg_reg[`TBS_IDX_HOLD] == `TBS_UNSET) ?
                       16'h0000 : cfg_reg[`TBS_IDX_HOLD];

   tbs_lag_filter u_filter (
      .clk_i   (clk_i),
      .srst_i  (srst_i),
      .tick_i  (tick_reg),
      .x_i     (target),
      .tc_i    (filt_tc),
      .y_o     (filt_y)
   );

   tbs_hold_timer u_hold (
      .clk_i        (clk_i),
      .srst_i       (srst_i),
      .start_i      (run_start),
      .run_i        (run_now),
      .tick_i       (tick_reg),
      .hold_ticks_i (hold_ticks),
      .active_o     (hold_act)
   );

   // Output registers toward the torque command path
   always @(posedge clk_i) begin
      if (srst_i) begin
         torque_bias_reg <= 16'sh0000;
         hold_reg        <= 1'b0;
         active_reg      <= 1'b0;
      end else begin
         torque_bias_reg <= filt_y;
         hold_reg        <= hold_act;
         active_reg      <= run_now && (sel == `TBS_SEL_SLOTS ||
                            sel == `TBS_SEL_ANA_FWD ||
                            sel == `TBS_SEL_ANA_REV);
      end
   end

   assign s_axi_awready_o = awready_reg;
   assign s_axi_wready_o  = wready_reg;
   assign s_axi_bresp_o   = bresp_reg;
   assign s_axi_bvalid_o  = bvalid_reg;
   assign s_axi_arready_o = arready_reg;
   assign s_axi_rdata_o   = rdata_reg;
   assign s_axi_rresp_o   = rresp_reg;
   assign s_axi_rvalid_o  = rvalid_reg;
   assign torque_bias_o   = torque_bias_reg;
   assign bias_hold_o     = hold_reg;
   assign bias_active_o   = active_reg;
endmodule // tbs_top
